// >>> include/dcpm_params.svh
// constants for the converter drive and current monitor block
// Summary of operation
// - third, fourth currents read-only, full scale 9.59 mA
// - fifth, sixth currents read-only, full scale 80.58 mA
// - period equals period code times tick
// - period bit 6 reads one; reset all ones
// - writing calibration bit starts routine; reads busy
// - read-only polarity bit fixed by device variant
// - minimum off time is code plus four ticks
// - width code sums on ticks, off code, four
`ifndef DCPM_PARAMS_SVH
`define DCPM_PARAMS_SVH
// register offsets on the serial control port
`define DCPM_ADDR_SENSE3 7'h56
`define DCPM_ADDR_SENSE4 7'h57
`define DCPM_ADDR_SENSE5 7'h58
`define DCPM_ADDR_SENSE6 7'h59
`define DCPM_ADDR_PERIOD 7'h5C
`define DCPM_ADDR_SWDLY 7'h5D
`define DCPM_ADDR_PW 7'h5E
// field positions and reset values
`define DCPM_PERIOD_RST 8'hFF
`define DCPM_PERIOD_FIXED 8'h40
`define DCPM_CAL_BIT 7
`define DCPM_POL_BIT 5
`define DCPM_TOF_RST 5'h00
`define DCPM_TOF_ADD 8'h04
// timing: tick of the converter and system clock, in picoseconds
`define DCPM_TICK_PS 61035
`define DCPM_CLK_PS 50000
// calibration routine length
`define DCPM_CAL_TIME_NS 100000
`define DCPM_CAL_CYCLES ((`DCPM_CAL_TIME_NS * 1000 + `DCPM_CLK_PS - 1) / `DCPM_CLK_PS)
`endif

// >>> include/dcpm_pkg.sv
// types shared by the converter drive block
package dcpm_pkg;
  // register access strobes from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dcpm_bus_t;
  // one conversion result from the monitoring converter
  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    logic [7:0] data;
  } dcpm_sense_t;
  typedef enum logic {CAL_IDLE, CAL_RUN} dcpm_cal_t;
endpackage

// >>> verilog/dcpm_spi_port.sv
// serial control port slave: command byte then data byte
`timescale 1ns/1ns
module dcpm_spi_port
  import dcpm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // conditioned serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  // register side
  input wire logic [7:0] rd_data,
  output dcpm_bus_t bus,
  // serial data out
  output logic sdo,
  output logic sdo_oe
);
  logic sclk_d_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic read_r;
  logic [7:0] tx_r;
  dcpm_bus_t bus_r;
  logic sdo_r;
  logic oe_r;
  // edge decode of the serial clock
  wire rise = sclk & ~sclk_d_r & ~cs_n;
  wire fall = ~sclk & sclk_d_r & ~cs_n;
  wire [7:0] byte_in = {shift_r[6:0], sdi};
  wire cmd_done = rise && (bit_cnt_r == 5'd7);
  wire dat_done = rise && (bit_cnt_r == 5'd15);
  wire in_data = (bit_cnt_r >= 5'd8) && (bit_cnt_r <= 5'd15);
  // shift in, issue strobes, shift out read data
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sclk_d_r <= 1'b1;
      bit_cnt_r <= 5'd0;
      shift_r <= 8'h00;
      read_r <= 1'b0;
      tx_r <= 8'h00;
      bus_r <= '0;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (ce) begin
      sclk_d_r <= sclk;
      bus_r.wr <= dat_done && !read_r;
      bus_r.rd <= cmd_done && byte_in[7];
      if (cs_n) begin
        bit_cnt_r <= 5'd0;
      end else if (rise && bit_cnt_r != 5'd16) begin
        bit_cnt_r <= bit_cnt_r + 5'd1;
        shift_r <= byte_in;
      end
      if (cmd_done) begin
        read_r <= byte_in[7];
        bus_r.addr <= byte_in[6:0];
      end
      if (dat_done) begin
        bus_r.wdata <= byte_in;
      end
      if (bus_r.rd) begin
        tx_r <= rd_data; // capture in the cycle after the command byte
      end else if (fall && in_data && read_r) begin
        sdo_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
      oe_r <= !cs_n && read_r && (bit_cnt_r >= 5'd8);
    end
  end
  assign bus = bus_r;
  assign sdo = sdo_r;
  assign sdo_oe = oe_r;
endmodule

// >>> verilog/dcpm_pwm_gen.sv
// pwm period, minimum off time and pulse width measurement
`timescale 1ns/1ns
`include "dcpm_params.svh"
module dcpm_pwm_gen #(
  parameter bit FF_SAME_POLARITY = 1'b0
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // timing and settings
  input wire logic tick,
  input wire logic [7:0] period,
  input wire logic [4:0] tof,
  input wire logic hold,
  input wire logic trip,
  // drive and result
  output logic drive,
  output logic ff,
  output logic [7:0] pw_code
);
  logic [7:0] cnt_r;
  logic [7:0] on_cnt_r;
  logic tripped_r;
  logic drive_r;
  logic ff_r;
  logic [7:0] pw_r;
  logic [7:0] per_s_r;
  logic [4:0] tof_s_r;
  // off ticks and the longest on phase of one period; settings are taken
  // only at a period boundary, so a write in the off phase cannot cut it short
  wire [7:0] off_min = {3'b000, tof_s_r} + `DCPM_TOF_ADD;
  wire [7:0] max_on = (per_s_r > off_min) ? (per_s_r - off_min) : 8'h00;
  wire last = (cnt_r >= per_s_r - 8'd1);
  wire [7:0] nidx = last ? 8'h00 : cnt_r + 8'd1;
  wire [7:0] on_done = on_cnt_r + {7'd0, drive_r};
  // a trip or a calibration hold keeps the drive off until the period ends
  wire trip_seen = (tripped_r && !last) || trip || hold;
  wire drive_nxt = !trip_seen && (nidx < max_on);
  // period counter, drive state and width capture on each tick
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      on_cnt_r <= 8'h00;
      tripped_r <= 1'b0;
      drive_r <= 1'b0;
      ff_r <= ~FF_SAME_POLARITY;
      pw_r <= 8'h00;
      per_s_r <= `DCPM_PERIOD_RST;
      tof_s_r <= `DCPM_TOF_RST;
    end else if (ce && tick) begin
      cnt_r <= nidx;
      tripped_r <= trip_seen;
      drive_r <= drive_nxt;
      ff_r <= drive_nxt ^ ~FF_SAME_POLARITY;
      if (last) begin
        on_cnt_r <= 8'h00;
        per_s_r <= period;
        tof_s_r <= tof;
        pw_r <= on_done + off_min;
      end else begin
        on_cnt_r <= on_done;
      end
    end
  end
  assign drive = drive_r;
  assign ff = ff_r;
  assign pw_code = pw_r;
endmodule

// >>> verilog/dcpm_top.sv
// top of the converter drive: pins, registers, calibration, sense results
`timescale 1ns/1ns
`include "dcpm_params.svh"
module dcpm_top
  import dcpm_pkg::*;
#(
  parameter bit FF_SAME_POLARITY = 1'b0,
  parameter int CAL_CYCLES = `DCPM_CAL_CYCLES
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // serial control port pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // monitoring converter results
  input dcpm_sense_t sense,
  // power stage
  input wire logic peak_trip_pin,
  output logic converter_drive_pin,
  output logic feedforward_pin,
  output logic cal_active
);
  localparam int NPIN = 4;
  localparam logic [NPIN-1:0] PIN_IDLE = 4'b0011;
  localparam logic [16:0] TICK_PS = 17'(`DCPM_TICK_PS);
  localparam logic [16:0] CLK_PS = 17'(`DCPM_CLK_PS);
  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

  // ---- pin conditioning
  wire [NPIN-1:0] pin_raw = {peak_trip_pin, spi_sdi, spi_cs_n, spi_sclk};
  wire [NPIN-1:0] pin_clean;

  // three stages per pin; the level moves once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic clean_r;
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          s1_r <= PIN_IDLE[gi];
          s2_r <= PIN_IDLE[gi];
          s3_r <= PIN_IDLE[gi];
          clean_r <= PIN_IDLE[gi];
        end else if (ce) begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            clean_r <= s3_r;
          end
        end
      end
      assign pin_clean[gi] = clean_r;
    end
  endgenerate

  wire sclk_c = pin_clean[0];
  wire cs_n_c = pin_clean[1];
  wire sdi_c = pin_clean[2];
  wire trip_c = pin_clean[3];

  // ---- converter tick from the system clock
  // the tick is not a whole number of clock periods, so a phase
  // accumulator spreads the error; the mean tick length is exact
  // and single ticks jitter by one clock period
  logic [16:0] acc_r;
  logic tick_r;
  wire [16:0] acc_sum = acc_r + CLK_PS;
  wire tick_hit = (acc_sum >= TICK_PS);
  wire [16:0] acc_nxt = tick_hit ? (acc_sum - TICK_PS) : acc_sum;

  // accumulator and one-cycle tick pulse
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acc_r <= 17'h0_0000;
      tick_r <= 1'b0;
    end else if (ce) begin
      acc_r <= acc_nxt;
      tick_r <= tick_hit;
    end
  end

  // ---- serial port
  dcpm_bus_t bus;
  wire [7:0] rd_data;

  dcpm_spi_port u_spi (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .sclk(sclk_c),
    .cs_n(cs_n_c),
    .sdi(sdi_c),
    .rd_data(rd_data),
    .bus(bus),
    .sdo(spi_sdo),
    .sdo_oe(spi_sdo_oe)
  );

  // ---- address decode
  wire wr_period = bus.wr && (bus.addr == `DCPM_ADDR_PERIOD);
  wire wr_swdly = bus.wr && (bus.addr == `DCPM_ADDR_SWDLY);
  wire hit_sense = (bus.addr >= `DCPM_ADDR_SENSE3) && (bus.addr <= `DCPM_ADDR_SENSE6);
  wire [6:0] sense_off = bus.addr - `DCPM_ADDR_SENSE3;
  wire [1:0] sense_idx = sense_off[1:0];

  // ---- period and off-time settings
  logic [7:0] period_r;
  logic [4:0] tof_r;
  // bit 6 is forced on every write so it always reads one
  wire [7:0] period_nxt = bus.wdata | `DCPM_PERIOD_FIXED;

  // software settings
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      period_r <= `DCPM_PERIOD_RST;
      tof_r <= `DCPM_TOF_RST;
    end else if (ce) begin
      if (wr_period) begin
        period_r <= period_nxt;
      end
      if (wr_swdly) begin
        tof_r <= bus.wdata[4:0];
      end
    end
  end

  // ---- peak current monitor calibration
  // the drive is held off while the routine runs, so the monitor
  // sees a quiet stage; a start written while busy is ignored
  dcpm_cal_t cal_state_r;
  dcpm_cal_t cal_state_nxt;
  logic [15:0] cal_cnt_r;
  logic [15:0] cal_cnt_nxt;
  logic cal_active_r;
  wire cal_start = wr_swdly && bus.wdata[`DCPM_CAL_BIT];
  wire cal_busy = (cal_state_r == CAL_RUN);
  wire cal_end = cal_busy && (cal_cnt_r == CAL_LAST);

  // next state of the calibration sequencer
  always_comb begin
    cal_state_nxt = cal_state_r;
    cal_cnt_nxt = cal_cnt_r;
    unique case (cal_state_r)
      CAL_IDLE: begin
        cal_cnt_nxt = 16'h0000;
        if (cal_start) begin
          cal_state_nxt = CAL_RUN;
        end
      end
      CAL_RUN: begin
        cal_cnt_nxt = cal_cnt_r + 16'h0001;
        if (cal_end) begin
          cal_state_nxt = CAL_IDLE;
          cal_cnt_nxt = 16'h0000;
        end
      end
    endcase
  end

  // calibration state registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cal_state_r <= CAL_IDLE;
      cal_cnt_r <= 16'h0000;
      cal_active_r <= 1'b0;
    end else if (ce) begin
      cal_state_r <= cal_state_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      cal_active_r <= (cal_state_nxt == CAL_RUN);
    end
  end

  // ---- transistor current results
  // no reset here: contents stay unknown until the first conversion
  wire [7:0] sense_w [4];
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sense
      logic [7:0] val_r;
      wire load = sense.valid && (sense.sel == 2'(gi));
      always_ff @(posedge clk_sys) begin
        if (ce && load) begin
          val_r <= sense.data;
        end
      end
      assign sense_w[gi] = val_r;
    end
  endgenerate

  // ---- pwm engine
  wire drive_w;
  wire ff_w;
  wire [7:0] pw_code_w;

  dcpm_pwm_gen #(
    .FF_SAME_POLARITY(FF_SAME_POLARITY)
  ) u_pwm (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .tick(tick_r),
    .period(period_r),
    .tof(tof_r),
    .hold(cal_busy),
    .trip(trip_c),
    .drive(drive_w),
    .ff(ff_w),
    .pw_code(pw_code_w)
  );

  // ---- read data
  wire pol_flag = FF_SAME_POLARITY;
  wire [7:0] swdly_rd = {cal_busy, 1'b0, pol_flag, tof_r};
  wire [7:0] sense_rd = sense_w[sense_idx];
  assign rd_data = hit_sense ? sense_rd :
                   (bus.addr == `DCPM_ADDR_PERIOD) ? period_r :
                   (bus.addr == `DCPM_ADDR_SWDLY) ? swdly_rd :
                   (bus.addr == `DCPM_ADDR_PW) ? pw_code_w :
                   8'h00; // unmapped offsets read zero

  // ---- outputs, each from a flip-flop
  assign converter_drive_pin = drive_w;
  assign feedforward_pin = ff_w;
  assign cal_active = cal_active_r;
endmodule

// >>> test/dcpm_top_asserts.sv
// pin-level assertions for the converter drive block
`timescale 1ns/1ns
module dcpm_asserts #(
  parameter bit FF_SAME_POLARITY = 1'b0,
  parameter int CAL_CYCLES = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // serial port
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  // power stage
  input wire logic peak_trip_pin,
  input wire logic converter_drive_pin,
  input wire logic feedforward_pin,
  input wire logic cal_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [15:0] cal_cnt_r;
  logic [9:0] on_cnt_r;
  // length of the current busy and on intervals
  always_ff @(posedge clk_sys) begin
    cal_cnt_r <= (!resetn || !cal_active) ? 16'h0000 : cal_cnt_r + 16'h0001;
    on_cnt_r <= (!resetn || !converter_drive_pin) ? 10'h000 : on_cnt_r + 10'h001;
  end
  property p_ff_pol;
    feedforward_pin == (converter_drive_pin ~^ FF_SAME_POLARITY);
  endproperty
  a_ff_pol: assert property (p_ff_pol) else $error("feedforward polarity wrong");
  property p_min_off;
    $fell(converter_drive_pin) |-> !converter_drive_pin [*4];
  endproperty
  a_min_off: assert property (p_min_off) else $error("off interval too short");
  property p_cal_quiet;
    cal_active && $past(cal_active) && $past(cal_active, 2) |-> !converter_drive_pin;
  endproperty
  a_cal_quiet: assert property (p_cal_quiet) else $error("drive on during calibration");
  property p_cal_len;
    $fell(cal_active) && $past(resetn) |-> cal_cnt_r == CAL_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  property p_on_bound;
    on_cnt_r <= 10'h1F6;
  endproperty
  a_on_bound: assert property (p_on_bound) else $error("drive on beyond a period");
  property p_trip;
    $rose(peak_trip_pin) |-> ##[1:6] !converter_drive_pin;
  endproperty
  a_trip: assert property (p_trip) else $error("peak trip ignored");
  property p_sdo_idle;
    spi_cs_n [*8] |-> !spi_sdo_oe;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while deselected");
  property p_reset;
    $rose(resetn) |-> !converter_drive_pin && !cal_active && !spi_sdo_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule
bind dcpm_top dcpm_asserts #(.FF_SAME_POLARITY(FF_SAME_POLARITY), .CAL_CYCLES(CAL_CYCLES)) u_asserts (
  .clk_sys(clk_sys), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .peak_trip_pin(peak_trip_pin), .converter_drive_pin(converter_drive_pin),
  .feedforward_pin(feedforward_pin), .cal_active(cal_active));

// >>> test/dcpm_stage_model.sv
// power stage model: inductor current ramps while drive is on
`timescale 1ns/1ns
module dcpm_stage_model (
  // clock and drive
  input wire logic clk_sys,
  input wire logic converter_drive_pin,
  // clocks of on time to reach peak, zero never trips
  input wire logic [9:0] trip_after,
  // peak current comparator
  output logic peak_trip_pin
);
  logic [9:0] ramp_r;
  // current builds with drive on and collapses when off
  always_ff @(posedge clk_sys) begin
    ramp_r <= converter_drive_pin ? ramp_r + 10'h001 : 10'h000;
    peak_trip_pin <= (trip_after != 10'h000) && converter_drive_pin && (ramp_r >= trip_after);
  end
endmodule

// >>> test/testbench.sv
// self-checking bench for the converter drive block
`timescale 1ns/1ns
module testbench
  import dcpm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sclk = 1'b1;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  dcpm_sense_t sense = '0;
  logic [9:0] trip_after = 10'h000;
  logic ce = 1'b1;
  logic lvl;
  logic sdo, sdo_oe, trip, drive, ff, cal;
  logic [7:0] rd;
  int n_fail = 0;
  int checked = 0;
  int cnt;
  int tot;
  always #25 clk_sys = ~clk_sys;
  dcpm_top #(.CAL_CYCLES(300)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .sense(sense),
    .peak_trip_pin(trip), .converter_drive_pin(drive), .feedforward_pin(ff), .cal_active(cal));
  dcpm_stage_model u_stage (.clk_sys(clk_sys), .converter_drive_pin(drive), .trip_after(trip_after),
    .peak_trip_pin(trip));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wclk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one frame, command then data; sdo sampled just before each rise
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
    logic [15:0] sh;
    sh = {cmd, wd};
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      wclk(8);
      sclk = 1'b0;
      sdi = sh[15-i];
      wclk(8);
      rd = {rd[6:0], sdo_oe ? sdo : ~sdo}; // released sdo reads inverted
      sclk = 1'b1;
    end
    wclk(8);
    cs_n = 1'b1;
    wclk(8);
  endtask
  // clocks until drive reaches lvl, bounded
  task automatic edge_wait(input logic lvl);
    cnt = 0;
    while (drive !== lvl && cnt < 2000) begin
      wclk(1);
      cnt++;
    end
    if (cnt == 2000) n_fail++;
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    wclk(20000);
    n_fail++;
    conclude();
  end
  initial begin
    wclk(2);
    resetn = 1'b1;
    wclk(4);
    xfer(8'hDC, 8'h00);
    check(rd, 8'hFF);
    xfer(8'hDD, 8'h00);
    check(rd, 8'h00);
    xfer(8'h5C, 8'h12);
    xfer(8'hDC, 8'h00);
    check(rd, 8'h52);
    $display("register test done");
    // each sense channel loads, ignores writes, up to full scale
    for (int n = 0; n < 4; n++) begin
      sense = {1'b1, 2'(n), 8'hFC + 8'(n)};
      wclk(1);
      sense.valid = 1'b0;
      xfer(8'h56 + 8'(n), 8'h00);
      xfer(8'hD6 + 8'(n), 8'h00);
      check(rd, 8'hFC + 8'(n));
    end
    $display("sense test done");
    // shortest period, off code 3: 8 periods of 64 ticks, 7 ticks off
    xfer(8'h5C, 8'h00);
    xfer(8'h5D, 8'h03);
    edge_wait(1'b0);
    edge_wait(1'b1);
    tot = 0;
    repeat (8) begin
      edge_wait(1'b0);
      tot += cnt;
      edge_wait(1'b1);
      tot += cnt;
    end
    check(8'(tot >= 623 && tot <= 627), 8'h01);
    edge_wait(1'b0);
    edge_wait(1'b1);
    check(8'(cnt >= 8 && cnt <= 10), 8'h01);
    xfer(8'hDE, 8'h00);
    check(rd, 8'h40);
    // peak trip cuts the pulse short
    trip_after = 10'd20;
    xfer(8'hDE, 8'h00);
    check(8'(rd >= 8'h10 && rd <= 8'h20), 8'h01);
    trip_after = 10'h000;
    // clock enable low freezes the drive
    lvl = drive;
    ce = 1'b0;
    cnt = 0;
    repeat (200) begin
      wclk(1);
      if (drive !== lvl) cnt++;
    end
    ce = 1'b1;
    check(8'(cnt), 8'h00);
    $display("pwm test done");
    // calibration reads busy, then clears
    xfer(8'h5D, 8'h83);
    check({7'h00, cal}, 8'h01);
    xfer(8'hDD, 8'h00);
    check(rd, 8'h83);
    wclk(60);
    xfer(8'hDD, 8'h00);
    check(rd, 8'h03);
    $display("calibration test done");
    conclude();
  end
endmodule
